/* File: rtl/wfpf_params.svh */
// Purpose: Constants of the wake frame pattern filter
// Assumes: Included by bare name from each design file but the package
// Notes:   Offsets are byte addresses of the controller register port
`ifndef WFPF_PARAMS_SVH
`define WFPF_PARAMS_SVH

// Checksum
`define WFPF_CRC_W        16
`define WFPF_CRC_INIT     16'hffff

// Pattern geometry
`define WFPF_MASK_BITS    128
`define WFPF_MASK_WORDS   4
`define WFPF_OFF_W        8
`define WFPF_IDX_W        10
`define WFPF_DA_BYTES     6
`define WFPF_DA_W         48

// Controller register map
`define WFPF_ADDR_W       6
`define WFPF_REG_CTRL     6'h00
`define WFPF_REG_OFFSET   6'h04
`define WFPF_REG_EXP_CRC  6'h08
`define WFPF_REG_DA_LOW   6'h0c
`define WFPF_REG_DA_MID   6'h10
`define WFPF_REG_DA_HIGH  6'h14
`define WFPF_REG_MASK0    6'h18
`define WFPF_REG_MASK3    6'h24
`define WFPF_REG_STATUS   6'h28
`define WFPF_REG_IRQ_MASK 6'h2c

// Control register fields
`define WFPF_CTRL_W       5
`define WFPF_CTRL_FILT_EN 0
`define WFPF_CTRL_ADDR_EN 1
`define WFPF_CTRL_MCAST   2
`define WFPF_CTRL_BCAST   3
`define WFPF_CTRL_DET_EN  4
`define WFPF_CTRL_RESET   5'h00

// Status register fields, write one to clear
`define WFPF_STAT_RCVD    0
`define WFPF_STAT_TRIG    1

// Interrupt mask register
`define WFPF_IRQ_W        16
`define WFPF_IRQ_WAKE_BIT 8

`endif

/* File: rtl/wfpf_pkg.sv */
// Purpose: Types of the wake frame pattern filter
// Assumes: Nothing beyond the params header
// Notes:   Used by scoped name only
package wfpf_pkg;

    typedef enum logic {
        WFPF_IDLE,
        WFPF_FRAME
    } wfpf_state_t;

endpackage : wfpf_pkg

/* File: rtl/wfpf_if.sv */
// Purpose: Configuration and status link between controller and filter
// Assumes: Both ends on one clock
// Notes:   Clear strobes are one-cycle pulses
`timescale 1ns/1ps
`include "wfpf_params.svh"

interface wfpf_if;
    logic [`WFPF_MASK_BITS-1:0] byte_mask;
    logic [`WFPF_CRC_W-1:0]     expected_crc;
    logic [`WFPF_OFF_W-1:0]     pattern_offset;
    logic [`WFPF_DA_W-1:0]      dest_addr;
    logic                       filter_en;
    logic                       addr_match_en;
    logic                       any_mcast_en;
    logic                       bcast_en;
    logic                       detect_en;
    logic                       irq_wake_en;
    logic                       clr_received;
    logic                       clr_triggered;
    logic                       received_flag;
    logic                       triggered_flag;

    modport dev (
        input  byte_mask, expected_crc, pattern_offset, dest_addr, filter_en,
        input  addr_match_en, any_mcast_en, bcast_en, detect_en, irq_wake_en,
        input  clr_received, clr_triggered,
        output received_flag, triggered_flag
    );

    modport host (
        output byte_mask, expected_crc, pattern_offset, dest_addr, filter_en,
        output addr_match_en, any_mcast_en, bcast_en, detect_en, irq_wake_en,
        output clr_received, clr_triggered,
        input  received_flag, triggered_flag
    );
endinterface : wfpf_if

/* File: rtl/wfpf_device.sv */
// Purpose: Wake frame detector: masked CRC-16 plus address qualifiers
// Assumes: Receive bytes arrive on CLK; end of frame is its own beat
// Notes:   A start beat inside a frame restarts the frame
`timescale 1ns/1ps
`include "wfpf_params.svh"

module wfpf_device (
    // Clock and reset
    input  wire logic                  CLK,
    input  wire logic                  NRST,
    // Receive byte stream
    input  wire logic                  RX_VALID,
    input  wire logic                  RX_SOF,
    input  wire logic [7:0]            RX_DATA,
    // Frame end and its checks
    input  wire logic                  RX_EOF,
    input  wire logic                  RX_FCS_OK,
    input  wire logic                  RX_LEN_OK,
    // Wake indication
    output logic                       WAKE_IRQ,
    output logic                       MATCH_PULSE,
    // Controller side
    wfpf_if.dev                        cfg
);

    localparam logic [`WFPF_IDX_W-1:0] IDX_MAX = '1;

    wfpf_pkg::wfpf_state_t   state_reg;
    wfpf_pkg::wfpf_state_t   state_next;
    logic [`WFPF_CRC_W-1:0]  crc_reg;
    logic [`WFPF_CRC_W-1:0]  crc_next;
    logic [`WFPF_IDX_W-1:0]  idx_reg;
    logic [`WFPF_IDX_W-1:0]  idx_next;
    logic [`WFPF_DA_W-1:0]   da_reg;
    logic [`WFPF_DA_W-1:0]   da_next;
    logic                    rcvd_reg;
    logic                    rcvd_next;
    logic                    trig_reg;
    logic                    trig_next;
    logic                    irq_reg;
    logic                    irq_next;
    logic                    pulse_reg;
    logic                    pulse_next;

    logic [`WFPF_CRC_W-1:0]  crc_base;
    logic [`WFPF_IDX_W-1:0]  idx_cur;
    logic                    take_byte;
    logic                    is_bcast;
    logic                    is_mcast;
    logic                    addr_hit;
    logic                    qual_ok;
    logic                    match;

    // One checksum step over a data byte
    function automatic logic [15:0] crc16_step(
        input logic [15:0] c,
        input logic [7:0]  d
    );
        logic [7:0]  f;
        logic [15:0] n;
        f[0] = c[15] ^ d[0];
        for (int i = 1; i < 8; i++) begin
            f[i] = c[15-i] ^ f[i-1] ^ d[i];
        end
        n[15] = c[7] ^ f[7];
        n[14:10] = c[6:2];
        n[9] = c[1] ^ f[0];
        n[8] = c[0] ^ f[1];
        for (int k = 2; k < 8; k++) begin
            n[k] = f[7-k] ^ f[9-k];
        end
        n[1] = f[6];
        n[0] = f[7];
        return n;
    endfunction : crc16_step

    // Is frame byte idx selected by offset and mask
    function automatic logic byte_selected(
        input logic [`WFPF_IDX_W-1:0]     idx,
        input logic [`WFPF_OFF_W-1:0]     off,
        input logic [`WFPF_MASK_BITS-1:0] mask
    );
        logic [`WFPF_IDX_W-1:0] rel;
        rel = idx - `WFPF_IDX_W'(off);
        if (idx < `WFPF_IDX_W'(off)) begin
            return 1'b0;
        end
        if (rel >= `WFPF_IDX_W'(`WFPF_MASK_BITS)) begin
            return 1'b0;
        end
        return mask[rel[6:0]];
    endfunction : byte_selected

    // Frame class and address qualification from captured address
    always_comb begin
        is_bcast = &da_reg;
        is_mcast = da_reg[0] & ~is_bcast;
        addr_hit = (da_reg == cfg.dest_addr);
        qual_ok  = 1'b0;
        if (is_bcast) begin
            qual_ok = cfg.bcast_en;
        end else if (is_mcast) begin
            qual_ok = cfg.any_mcast_en | (cfg.addr_match_en & addr_hit);
        end else begin
            qual_ok = ~cfg.addr_match_en | addr_hit;
        end
    end

    // Frame walk, checksum and address capture
    always_comb begin
        state_next = state_reg;
        crc_next   = crc_reg;
        idx_next   = idx_reg;
        da_next    = da_reg;
        crc_base   = crc_reg;
        idx_cur    = idx_reg;
        take_byte  = 1'b0;
        match      = 1'b0;
        case (state_reg)
            wfpf_pkg::WFPF_IDLE: begin
                if (RX_VALID && RX_SOF) begin
                    take_byte  = 1'b1;
                    state_next = wfpf_pkg::WFPF_FRAME;
                end
            end
            wfpf_pkg::WFPF_FRAME: begin
                if (RX_VALID) begin
                    take_byte = 1'b1;
                end else if (RX_EOF) begin
                    state_next = wfpf_pkg::WFPF_IDLE;
                    // Late compare so that FCS and length are final
                    match = cfg.filter_en & cfg.detect_en
                          & (crc_reg == cfg.expected_crc)
                          & RX_FCS_OK & RX_LEN_OK
                          & qual_ok;
                end
            end
            default: begin
                state_next = wfpf_pkg::WFPF_IDLE;
            end
        endcase
        if (RX_VALID && RX_SOF) begin
            crc_base = `WFPF_CRC_INIT;
            idx_cur  = '0;
        end
        if (take_byte) begin
            if (byte_selected(idx_cur, cfg.pattern_offset, cfg.byte_mask)) begin
                crc_next = crc16_step(crc_base, RX_DATA);
            end else begin
                crc_next = crc_base;
            end
            for (int b = 0; b < `WFPF_DA_BYTES; b++) begin
                if (idx_cur == `WFPF_IDX_W'(b)) begin
                    da_next[b*8 +: 8] = RX_DATA;
                end
            end
            // Saturate so a giant frame cannot wrap into the mask window
            if (idx_cur != IDX_MAX) begin
                idx_next = idx_cur + 1'b1;
            end else begin
                idx_next = idx_cur;
            end
        end
    end

    // Sticky flags; a set in the clear cycle wins
    always_comb begin
        rcvd_next  = (rcvd_reg & ~cfg.clr_received) | match;
        trig_next  = (trig_reg & ~cfg.clr_triggered) | match;
        irq_next   = rcvd_next & cfg.irq_wake_en;
        pulse_next = match;
    end

    always_ff @(posedge CLK) begin
        if (!NRST) begin
            state_reg <= wfpf_pkg::WFPF_IDLE;
            crc_reg   <= `WFPF_CRC_INIT;
            idx_reg   <= '0;
            da_reg    <= '0;
            rcvd_reg  <= 1'b0;
            trig_reg  <= 1'b0;
            irq_reg   <= 1'b0;
            pulse_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            crc_reg   <= crc_next;
            idx_reg   <= idx_next;
            da_reg    <= da_next;
            rcvd_reg  <= rcvd_next;
            trig_reg  <= trig_next;
            irq_reg   <= irq_next;
            pulse_reg <= pulse_next;
        end
    end

    assign cfg.received_flag  = rcvd_reg;
    assign cfg.triggered_flag = trig_reg;
    assign WAKE_IRQ           = irq_reg;
    assign MATCH_PULSE        = pulse_reg;

endmodule : wfpf_device

/* File: rtl/wfpf_host.sv */
// Purpose: Controller end: software registers driving the wake filter
// Assumes: Plain register port, read data one cycle after the strobe
// Notes:   Any pattern or address write drops the filter enable
`timescale 1ns/1ps
`include "wfpf_params.svh"

module wfpf_host (
    // Clock and reset
    input  wire logic                    CLK,
    input  wire logic                    NRST,
    // Software register port
    input  wire logic [`WFPF_ADDR_W-1:0] REG_ADDR,
    input  wire logic [31:0]             REG_WDATA,
    input  wire logic                    REG_WR,
    input  wire logic                    REG_RD,
    output logic      [31:0]             REG_RDATA,
    // Filter side
    wfpf_if.host                         cfg
);

    logic [`WFPF_CTRL_W-1:0] ctrl_reg;
    logic [`WFPF_CTRL_W-1:0] ctrl_next;
    logic [`WFPF_OFF_W-1:0]  off_reg;
    logic [`WFPF_OFF_W-1:0]  off_next;
    logic [`WFPF_CRC_W-1:0]  exp_reg;
    logic [`WFPF_CRC_W-1:0]  exp_next;
    logic [15:0]             da_reg   [3];
    logic [15:0]             da_next  [3];
    logic [31:0]             mask_reg [`WFPF_MASK_WORDS];
    logic [31:0]             mask_next[`WFPF_MASK_WORDS];
    logic [`WFPF_IRQ_W-1:0]  irqm_reg;
    logic [`WFPF_IRQ_W-1:0]  irqm_next;
    logic [31:0]             rdata_reg;
    logic [31:0]             rdata_next;
    logic                    cfg_write;

    // Map a byte address onto a mask word, or -1
    function automatic int mask_index(input logic [`WFPF_ADDR_W-1:0] a);
        if (a >= `WFPF_REG_MASK0 && a <= `WFPF_REG_MASK3 && a[1:0] == 2'b00) begin
            return int'((a - `WFPF_REG_MASK0) >> 2);
        end
        return -1;
    endfunction : mask_index

    always_comb begin
        ctrl_next = ctrl_reg;
        off_next  = off_reg;
        exp_next  = exp_reg;
        da_next   = da_reg;
        mask_next = mask_reg;
        irqm_next = irqm_reg;
        cfg_write = 1'b0;
        if (REG_WR) begin
            case (REG_ADDR)
                `WFPF_REG_CTRL: begin
                    ctrl_next = REG_WDATA[`WFPF_CTRL_W-1:0];
                end
                `WFPF_REG_OFFSET: begin
                    off_next  = REG_WDATA[`WFPF_OFF_W-1:0];
                    cfg_write = 1'b1;
                end
                `WFPF_REG_EXP_CRC: begin
                    exp_next  = REG_WDATA[`WFPF_CRC_W-1:0];
                    cfg_write = 1'b1;
                end
                `WFPF_REG_DA_LOW: begin
                    da_next[0] = REG_WDATA[15:0];
                    cfg_write  = 1'b1;
                end
                `WFPF_REG_DA_MID: begin
                    da_next[1] = REG_WDATA[15:0];
                    cfg_write  = 1'b1;
                end
                `WFPF_REG_DA_HIGH: begin
                    da_next[2] = REG_WDATA[15:0];
                    cfg_write  = 1'b1;
                end
                `WFPF_REG_IRQ_MASK: begin
                    irqm_next = REG_WDATA[`WFPF_IRQ_W-1:0];
                end
                default: begin
                    if (mask_index(REG_ADDR) >= 0) begin
                        mask_next[mask_index(REG_ADDR)] = REG_WDATA;
                        cfg_write = 1'b1;
                    end
                end
            endcase
        end
        // Filter never runs on a half-written pattern
        if (cfg_write) begin
            ctrl_next[`WFPF_CTRL_FILT_EN] = 1'b0;
        end
    end

    always_comb begin
        rdata_next = 32'h0000_0000;
        if (REG_RD) begin
            case (REG_ADDR)
                `WFPF_REG_CTRL:     rdata_next = 32'(ctrl_reg);
                `WFPF_REG_OFFSET:   rdata_next = 32'(off_reg);
                `WFPF_REG_EXP_CRC:  rdata_next = 32'(exp_reg);
                `WFPF_REG_DA_LOW:   rdata_next = 32'(da_reg[0]);
                `WFPF_REG_DA_MID:   rdata_next = 32'(da_reg[1]);
                `WFPF_REG_DA_HIGH:  rdata_next = 32'(da_reg[2]);
                `WFPF_REG_IRQ_MASK: rdata_next = 32'(irqm_reg);
                `WFPF_REG_STATUS: begin
                    rdata_next[`WFPF_STAT_RCVD] = cfg.received_flag;
                    rdata_next[`WFPF_STAT_TRIG] = cfg.triggered_flag;
                end
                default: begin
                    if (mask_index(REG_ADDR) >= 0) begin
                        rdata_next = mask_reg[mask_index(REG_ADDR)];
                    end
                end
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (!NRST) begin
            ctrl_reg  <= `WFPF_CTRL_RESET;
            off_reg   <= '0;
            exp_reg   <= '0;
            da_reg    <= '{default: 16'h0000};
            mask_reg  <= '{default: 32'h0000_0000};
            irqm_reg  <= '0;
            rdata_reg <= 32'h0000_0000;
        end else begin
            ctrl_reg  <= ctrl_next;
            off_reg   <= off_next;
            exp_reg   <= exp_next;
            da_reg    <= da_next;
            mask_reg  <= mask_next;
            irqm_reg  <= irqm_next;
            rdata_reg <= rdata_next;
        end
    end

    // Write one to clear, a pulse in the write cycle
    assign cfg.clr_received  = REG_WR & (REG_ADDR == `WFPF_REG_STATUS)
                             & REG_WDATA[`WFPF_STAT_RCVD];
    assign cfg.clr_triggered = REG_WR & (REG_ADDR == `WFPF_REG_STATUS)
                             & REG_WDATA[`WFPF_STAT_TRIG];

    assign cfg.byte_mask      = {mask_reg[3], mask_reg[2], mask_reg[1], mask_reg[0]};
    assign cfg.expected_crc   = exp_reg;
    assign cfg.pattern_offset = off_reg;
    assign cfg.dest_addr      = {da_reg[2], da_reg[1], da_reg[0]};
    assign cfg.filter_en      = ctrl_reg[`WFPF_CTRL_FILT_EN];
    assign cfg.addr_match_en  = ctrl_reg[`WFPF_CTRL_ADDR_EN];
    assign cfg.any_mcast_en   = ctrl_reg[`WFPF_CTRL_MCAST];
    assign cfg.bcast_en       = ctrl_reg[`WFPF_CTRL_BCAST];
    assign cfg.detect_en      = ctrl_reg[`WFPF_CTRL_DET_EN];
    assign cfg.irq_wake_en    = irqm_reg[`WFPF_IRQ_WAKE_BIT];
    assign REG_RDATA          = rdata_reg;

endmodule : wfpf_host

/* File: dv/wfpf_checker.sv */
// Purpose: Concurrent checks on the filter link and the wake outputs
// Assumes: One clock, NRST synchronous and active low
// Notes:   Takes the link signals as plain inputs, no bind
`timescale 1ns/1ps

module wfpf_checker (
    // Clock and reset
    input wire logic CLK,
    input wire logic NRST,
    // Device outputs
    input wire logic MATCH_PULSE,
    input wire logic WAKE_IRQ,
    // Link enables and clears
    input wire logic filter_en,
    input wire logic detect_en,
    input wire logic irq_wake_en,
    input wire logic clr_received,
    input wire logic clr_triggered,
    // Link status
    input wire logic received_flag,
    input wire logic triggered_flag
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!NRST);

    property p_rcvd_cause;
        $rose(received_flag) |-> MATCH_PULSE;
    endproperty
    a_rcvd_cause: assert property (p_rcvd_cause)
        else $error("received flag rose without a match");

    property p_trig_cause;
        $rose(triggered_flag) |-> MATCH_PULSE;
    endproperty
    a_trig_cause: assert property (p_trig_cause)
        else $error("triggered flag rose without a match");

    property p_match_flags;
        MATCH_PULSE |-> received_flag && triggered_flag;
    endproperty
    a_match_flags: assert property (p_match_flags)
        else $error("match without both flags");

    property p_match_enabled;
        MATCH_PULSE |-> $past(filter_en && detect_en);
    endproperty
    a_match_enabled: assert property (p_match_enabled)
        else $error("match while filter or detection off");

    property p_match_single;
        MATCH_PULSE |=> !MATCH_PULSE;
    endproperty
    a_match_single: assert property (p_match_single)
        else $error("match pulse longer than one cycle");

    // Received flag is sticky, so only a clear may drop it
    property p_rcvd_hold;
        received_flag && !clr_received |=> received_flag;
    endproperty
    a_rcvd_hold: assert property (p_rcvd_hold)
        else $error("received flag dropped without clear");

    property p_rcvd_clear;
        clr_received |=> !received_flag || MATCH_PULSE;
    endproperty
    a_rcvd_clear: assert property (p_rcvd_clear)
        else $error("received flag not cleared");

    property p_trig_clear;
        clr_triggered |=> !triggered_flag || MATCH_PULSE;
    endproperty
    a_trig_clear: assert property (p_trig_clear)
        else $error("triggered flag not cleared");

    property p_irq_level;
        WAKE_IRQ == (received_flag && $past(irq_wake_en));
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("wake irq disagrees with flag and mask");
endmodule : wfpf_checker

/* File: dv/wake_frame_pattern_filter_tb.sv */
// Purpose: Register driven tests of the wake frame pattern filter
// Assumes: Host and device joined by the link interface
// Notes:   Expected checksums come from a bench model of the update
`timescale 1ns/1ps
`include "wfpf_params.svh"

module wake_frame_pattern_filter_tb;
    logic         clk;
    logic         nrst = 1'b0;
    logic [5:0]   reg_addr = 6'h00;
    logic [31:0]  reg_wdata = 32'h0;
    logic         reg_wr_s = 1'b0;
    logic         reg_rd_s = 1'b0;
    logic [31:0]  reg_rdata;
    logic         rx_valid = 1'b0;
    logic         rx_sof = 1'b0;
    logic [7:0]   rx_data = 8'h00;
    logic         rx_eof = 1'b0;
    logic         rx_fcs_ok = 1'b0;
    logic         rx_len_ok = 1'b0;
    logic         wake_irq;
    logic         match_pulse;
    logic [7:0]   frm [0:31];
    logic [7:0]   da [0:5];
    logic [7:0]   off;
    logic [127:0] mask;
    logic         irq;
    int           flen = 20;
    int           n_mismatch = 0;
    int           samples_checked = 0;

    wfpf_if wif ();
    wfpf_device wfpf_device_i (.CLK(clk), .NRST(nrst), .RX_VALID(rx_valid), .RX_SOF(rx_sof),
        .RX_DATA(rx_data), .RX_EOF(rx_eof), .RX_FCS_OK(rx_fcs_ok), .RX_LEN_OK(rx_len_ok),
        .WAKE_IRQ(wake_irq), .MATCH_PULSE(match_pulse), .cfg(wif.dev));
    wfpf_host wfpf_host_i (.CLK(clk), .NRST(nrst), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
        .REG_WR(reg_wr_s), .REG_RD(reg_rd_s), .REG_RDATA(reg_rdata), .cfg(wif.host));
    wfpf_checker wfpf_checker_i (.CLK(clk), .NRST(nrst), .MATCH_PULSE(match_pulse),
        .WAKE_IRQ(wake_irq), .filter_en(wif.filter_en), .detect_en(wif.detect_en),
        .irq_wake_en(wif.irq_wake_en), .clr_received(wif.clr_received),
        .clr_triggered(wif.clr_triggered), .received_flag(wif.received_flag),
        .triggered_flag(wif.triggered_flag));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] expv, input string what);
        samples_checked++;
        if (seen !== expv) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, expv, seen);
        end
    endtask : check

    task automatic complete_run();
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : complete_run

    // A gap cycle after each strobe keeps one assignment per time step
    task automatic reg_wr(input logic [5:0] a, input logic [31:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr_s  <= 1'b1;
        @(posedge clk);
        reg_wr_s  <= 1'b0;
        @(posedge clk);
    endtask : reg_wr

    task automatic reg_rd(input logic [5:0] a, input logic [31:0] expv, input string what);
        reg_addr <= a;
        reg_rd_s <= 1'b1;
        @(posedge clk);
        reg_rd_s <= 1'b0;
        #1;
        check(reg_rdata, expv, what);
        @(posedge clk);
    endtask : reg_rd

    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
        logic [7:0]  f;
        logic [15:0] n;
        f[0] = c[15] ^ d[0];
        for (int i = 1; i < 8; i++) begin
            f[i] = c[15-i] ^ f[i-1] ^ d[i];
        end
        n[15]    = c[7] ^ f[7];
        n[14:10] = c[6:2];
        n[9]     = c[1] ^ f[0];
        n[8]     = c[0] ^ f[1];
        for (int k = 2; k < 8; k++) begin
            n[k] = f[7-k] ^ f[9-k];
        end
        n[1] = f[6];
        n[0] = f[7];
        return n;
    endfunction : crc_step

    function automatic logic [15:0] exp_crc();
        logic [15:0] c;
        c = `WFPF_CRC_INIT;
        for (int j = 0; j < 128; j++) begin
            if (mask[j] && (int'(off) + j < flen)) begin
                c = crc_step(c, frm[int'(off) + j]);
            end
        end
        return c;
    endfunction : exp_crc

    function automatic logic qual_exp(input int t, input int a, input logic [4:0] c);
        logic q;
        q = (t == 0) ? (!c[1] || a == 1) : (t == 1) ? (c[2] || (c[1] && a == 1)) : c[3];
        return c[0] && c[4] && q;
    endfunction : qual_exp

    // Type 0 unicast, 1 multicast, 2 broadcast; a clear means address mismatch
    task automatic set_da(input int t, input int a);
        for (int i = 0; i < 6; i++) begin
            frm[i] = (t == 2) ? 8'hff : (i == 0) ? 8'(2 + t) : 8'(i * 17);
            da[i] = frm[i];
        end
        if (a == 0) da[5] = da[5] ^ 8'h01;
    endtask : set_da

    task automatic program_filter(input logic [4:0] ctrl);
        reg_wr(`WFPF_REG_OFFSET, {24'h0, off});
        for (int w = 0; w < 4; w++) begin
            reg_wr(6'(`WFPF_REG_MASK0 + 4 * w), mask[32*w +: 32]);
        end
        reg_wr(`WFPF_REG_EXP_CRC, {16'h0, exp_crc()});
        reg_wr(`WFPF_REG_DA_LOW, {16'h0, da[1], da[0]});
        reg_wr(`WFPF_REG_DA_MID, {16'h0, da[3], da[2]});
        reg_wr(`WFPF_REG_DA_HIGH, {16'h0, da[5], da[4]});
        reg_wr(`WFPF_REG_IRQ_MASK, {23'h0, irq, 8'h00});
        reg_wr(`WFPF_REG_CTRL, {27'h0, ctrl});
    endtask : program_filter

    task automatic send_frame(input logic fcs, input logic len, input logic expv);
        for (int i = 0; i < flen; i++) begin
            rx_valid <= 1'b1;
            rx_sof   <= (i == 0);
            rx_data  <= frm[i];
            @(posedge clk);
        end
        rx_valid  <= 1'b0;
        rx_sof    <= 1'b0;
        rx_eof    <= 1'b1;
        rx_fcs_ok <= fcs;
        rx_len_ok <= len;
        @(posedge clk);
        rx_eof <= 1'b0;
        #1;
        check(match_pulse, expv, "match pulse");
        check(wake_irq, expv && irq, "wake irq");
        @(posedge clk);
        reg_rd(`WFPF_REG_STATUS, {30'h0, expv, expv}, "status");
        reg_wr(`WFPF_REG_STATUS, 32'h3);
    endtask : send_frame

    initial begin
        repeat (40000) @(posedge clk);
        n_mismatch++;
        complete_run();
    end

    initial begin
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        reg_rd(`WFPF_REG_CTRL, 32'h0, "ctrl reset");
        reg_rd(`WFPF_REG_STATUS, 32'h0, "status reset");
        reg_wr(6'h30, 32'hffffffff);
        reg_rd(6'h30, 32'h0, "unmapped");
        // Unicast pattern at offset three, last mask bit past the frame
        for (int i = 0; i < 32; i++) begin
            frm[i] = 8'(i * 29 + 7);
        end
        set_da(0, 1);
        off = 8'h03;
        mask = {32'h8000_0000, 64'h0, 32'h0000_0f0b};
        irq = 1'b1;
        program_filter(5'h11);
        reg_rd(`WFPF_REG_CTRL, 32'h11, "ctrl");
        // A pattern write must drop the filter enable
        reg_wr(`WFPF_REG_OFFSET, {24'h0, off});
        reg_rd(`WFPF_REG_CTRL, 32'h10, "ctrl after offset write");
        reg_wr(`WFPF_REG_CTRL, 32'h11);
        send_frame(1'b1, 1'b1, 1'b1);
        send_frame(1'b1, 1'b1, 1'b1);
        frm[4] = ~frm[4];
        send_frame(1'b1, 1'b1, 1'b0);
        frm[4] = ~frm[4];
        frm[5] = ~frm[5];
        send_frame(1'b1, 1'b1, 1'b1);
        frm[5] = ~frm[5];
        send_frame(1'b0, 1'b1, 1'b0);
        send_frame(1'b1, 1'b0, 1'b0);
        // Every frame type against every enable mix, offset zero
        off = 8'h00;
        mask = {96'h0, 32'h000f_c3a5};
        for (int t = 0; t < 3; t++) begin
            for (int a = 0; a < 2; a++) begin
                for (int c = 0; c < 32; c++) begin
                    set_da(t, a);
                    irq = a[0];
                    program_filter(5'(c));
                    send_frame(1'b1, 1'b1, qual_exp(t, a, 5'(c)));
                end
            end
        end
        complete_run();
    end
endmodule : wake_frame_pattern_filter_tb
